//--- core/hvmr_routing.sv
// Purpose: Control of the high-voltage measurement switch and pin gating
// Assumes: Mode from the mode controller on the same clock; pin levels async
// Notes: Sleep requests are checked here; restart is a one-cycle request
//
// Our own choices: the register addresses and the address-and-strobe port.
`include "hvmr_consts.svh"
`timescale 1ns/10ps
`default_nettype none

module hvmr_routing (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    // Register port
    input wire hvmr_pkg::hvmr_bus_req_type i_bus,
    output logic [7:0] o_rdata,
    // Mode controller
    input wire hvmr_pkg::hvmr_mode_type i_mode,
    input wire logic i_sleep_cmd,
    input wire logic i_other_wake_src,
    output logic o_restart_req,
    // Pins
    input wire logic i_hv_sense_level,
    input wire logic i_gio_level,
    output hvmr_pkg::hvmr_pin_ctrl_type o_pin,
    // Interrupt
    output logic o_irq
);

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    hvmr_pkg::hvmr_state_type s_q; // Registered state
    hvmr_pkg::hvmr_state_type s_d; // Next state
    logic normal_mode; // Normal mode decode
    logic gio_active; // General pin not off
    logic hv_wake_ok; // Sense input may wake
    logic gio_wake_ok; // General pin may wake
    logic [1:0] wake_ev; // Edge events
    logic [1:0] clr_err; // Write-one clear mask

    assign normal_mode = (i_mode == hvmr_pkg::HVMR_MODE_NORMAL);
    assign gio_active = (s_q.gio_cfg != `HVMR_GIO_OFF);
    // Wake paths are gated while measuring, stored bits stay untouched
    assign hv_wake_ok = s_q.wake_cfg[`HVMR_BIT_HV_WAKE_EN] && !s_q.meas_en;
    assign gio_wake_ok = (s_q.gio_cfg == `HVMR_GIO_WAKE_IN) && !s_q.meas_en;

    // ---------------------------------------------------------------
    // Pin controls, combinational so the switch opens with the mode
    // ---------------------------------------------------------------
    always_comb begin
        // Closed only in normal mode; fail-safe and others keep it open
        o_pin.meas_switch = s_q.meas_en && normal_mode && !gio_active;
        // Pull currents off while measuring, otherwise as configured
        o_pin.hv_pull_up = !s_q.meas_en && s_q.wake_cfg[`HVMR_PULL_LSB];
        o_pin.hv_pull_down = !s_q.meas_en && s_q.wake_cfg[`HVMR_PULL_LSB+1];
        // Fail output and its test unavailable while measuring
        o_pin.gio_fail_drive = !s_q.meas_en && (s_q.gio_cfg == `HVMR_GIO_FAIL_OUT)
                               && s_q.fo_test;
        o_pin.gio_wake_active = gio_wake_ok;
        o_pin.hv_wake_active = hv_wake_ok;
    end

    // ---------------------------------------------------------------
    // Next-state logic
    // ---------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.restart_req = 1'b0;
        // Two-stage synchronisers for pin levels
        s_d.hv_sync = {s_q.hv_sync[0], i_hv_sense_level};
        s_d.gio_sync = {s_q.gio_sync[0], i_gio_level};
        s_d.hv_prev = s_q.hv_sync[1];
        s_d.gio_prev = s_q.gio_sync[1];
        // Gated inputs: no edge events while measuring
        wake_ev[0] = hv_wake_ok && (s_q.hv_sync[1] != s_q.hv_prev);
        wake_ev[1] = gio_wake_ok && (s_q.gio_sync[1] != s_q.gio_prev);
        clr_err = 2'b00;
        if (i_bus.wr && i_bus.addr == `HVMR_ADDR_IRQ_STAT) begin
            clr_err = i_bus.wdata[1:0];
        end
        s_d.irq_stat = s_q.irq_stat & ~clr_err;
        // Wake and level status frozen while measuring
        if (!s_q.meas_en) begin
            s_d.level_stat = {s_q.gio_sync[1], s_q.hv_sync[1]};
            s_d.wake_stat = s_q.wake_stat | wake_ev;
        end
        if (i_bus.wr && i_bus.addr == `HVMR_ADDR_WAKE_STAT) begin
            s_d.wake_stat = (s_q.wake_stat & ~i_bus.wdata[1:0]) | wake_ev;
        end
        if (wake_ev != 2'b00) begin
            s_d.irq_stat[`HVMR_IRQ_WAKE] = 1'b1;
        end
        // Register writes
        if (i_bus.wr) begin
            unique case (i_bus.addr)
                `HVMR_ADDR_CTRL: begin
                    // Refuse enable while general pin is active
                    if (i_bus.wdata[`HVMR_BIT_MEAS_EN] && !s_q.meas_en && gio_active) begin
                        s_d.irq_stat[`HVMR_IRQ_CMD_ERR] = 1'b1;
                    end else begin
                        s_d.meas_en = i_bus.wdata[`HVMR_BIT_MEAS_EN];
                    end
                    s_d.fo_test = i_bus.wdata[`HVMR_BIT_FO_TEST];
                end
                `HVMR_ADDR_WAKE_CFG: begin
                    s_d.wake_cfg = i_bus.wdata;
                end
                `HVMR_ADDR_GIO_CFG: begin
                    // Changes refused and flagged while measuring
                    if (s_q.meas_en) begin
                        s_d.irq_stat[`HVMR_IRQ_CMD_ERR] = 1'b1;
                    end else begin
                        s_d.gio_cfg = i_bus.wdata[2:0];
                    end
                end
                `HVMR_ADDR_IRQ_MASK: begin
                    s_d.irq_mask = i_bus.wdata[1:0];
                end
                default: begin
                end
            endcase
        end
        // Sleep with only the gated pins as wake sources is refused
        if (i_sleep_cmd && s_q.meas_en && !i_other_wake_src
            && (s_q.wake_cfg[`HVMR_BIT_HV_WAKE_EN] || s_q.gio_cfg == `HVMR_GIO_WAKE_IN)) begin
            s_d.irq_stat[`HVMR_IRQ_CMD_ERR] = 1'b1;
            s_d.restart_req = 1'b1;
        end
        // Read data, one cycle later
        s_d.rdata = `HVMR_RST_WORD;
        if (i_bus.rd) begin
            unique case (i_bus.addr)
                `HVMR_ADDR_CTRL: s_d.rdata = {6'h00, s_q.fo_test, s_q.meas_en};
                `HVMR_ADDR_WAKE_CFG: s_d.rdata = s_q.wake_cfg;
                `HVMR_ADDR_GIO_CFG: s_d.rdata = {5'h00, s_q.gio_cfg};
                `HVMR_ADDR_STATUS: s_d.rdata = {5'h00, s_q.level_stat, o_pin.meas_switch};
                `HVMR_ADDR_IRQ_STAT: s_d.rdata = {6'h00, s_q.irq_stat};
                `HVMR_ADDR_IRQ_MASK: s_d.rdata = {6'h00, s_q.irq_mask};
                `HVMR_ADDR_WAKE_STAT: s_d.rdata = {6'h00, s_q.wake_stat};
                default: s_d.rdata = `HVMR_RST_WORD;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // State register; reset leaves measurement off
    // ---------------------------------------------------------------
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_rdata = s_q.rdata;
    assign o_restart_req = s_q.restart_req;
    assign o_irq = |(s_q.irq_stat & s_q.irq_mask);

endmodule

`default_nettype wire

//--- include/hvmr_consts.svh
// Purpose: Constants for the high-voltage measurement routing block
// Assumes: Included by the design file, the bench and the monitor
// Notes: Functional notes follow
//
// Functional notes
// - After reset measurement off, switch open
// - Enable bit closes switch in normal mode
// - Other modes open switch, enable kept
// - Enabled: pulls off, pin inputs gated
// - Enabled: wake settings ignored but stored
// - Enabled: wake and level status frozen
// - Enabled: sleep with only pin wakes: error, restart
// - Enabled: no fail, general or wake function
// - Enabled: general pin config change flags error
// - Active pin config refuses enable, flags error
// - Enabled: wake enable bits writable but ineffective
// - Fail-safe keeps enable, switch open
// - Route sensed voltage only with general pin off
`ifndef HVMR_CONSTS_SVH
`define HVMR_CONSTS_SVH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define HVMR_ADDR_CTRL 4'h0
`define HVMR_ADDR_WAKE_CFG 4'h1
`define HVMR_ADDR_GIO_CFG 4'h2
`define HVMR_ADDR_STATUS 4'h3
`define HVMR_ADDR_IRQ_STAT 4'h4
`define HVMR_ADDR_IRQ_MASK 4'h5
`define HVMR_ADDR_WAKE_STAT 4'h6

// ---------------------------------------------------------------
// Field positions and reset values
// ---------------------------------------------------------------
`define HVMR_BIT_MEAS_EN 0
`define HVMR_BIT_FO_TEST 1
`define HVMR_BIT_HV_WAKE_EN 0
`define HVMR_BIT_GIO_WAKE_EN 1
`define HVMR_PULL_LSB 2
`define HVMR_IRQ_CMD_ERR 0
`define HVMR_IRQ_WAKE 1
`define HVMR_GIO_OFF 3'h0
`define HVMR_GIO_FAIL_OUT 3'h1
`define HVMR_GIO_WAKE_IN 3'h2
`define HVMR_RST_WORD 8'h00

`endif

//--- include/hvmr_pkg.sv
// Purpose: Types for the high-voltage measurement routing block
// Assumes: Constants come from hvmr_consts.svh
// Notes: Mode encoding is owned by the mode controller outside
package hvmr_pkg;

    // ---------------------------------------------------------------
    // Operating modes seen from the mode controller
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        HVMR_MODE_INIT,
        HVMR_MODE_NORMAL,
        HVMR_MODE_STOP,
        HVMR_MODE_SLEEP,
        HVMR_MODE_RESTART,
        HVMR_MODE_FAILSAFE
    } hvmr_mode_type;

    // Register port request
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } hvmr_bus_req_type;

    // Pin-facing controls
    typedef struct packed {
        logic meas_switch;
        logic hv_pull_up;
        logic hv_pull_down;
        logic gio_fail_drive;
        logic gio_wake_active;
        logic hv_wake_active;
    } hvmr_pin_ctrl_type;

    // Whole block state
    typedef struct packed {
        logic meas_en;
        logic fo_test;
        logic [7:0] wake_cfg;
        logic [2:0] gio_cfg;
        logic [1:0] irq_stat;
        logic [1:0] irq_mask;
        logic [1:0] wake_stat;
        logic [1:0] level_stat;
        logic [1:0] hv_sync;
        logic [1:0] gio_sync;
        logic hv_prev;
        logic gio_prev;
        logic restart_req;
        logic [7:0] rdata;
    } hvmr_state_type;

endpackage

//--- sim/hv_voltage_measure_routing_tb.sv
// Purpose: Self-checking bench for the measurement routing block
// Assumes: 25 MHz clock, reset held 8 cycles
// Notes: Reset values first, then enable refusal, mode rows, pin refusal, freezing and sleep
`include "hvmr_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module hv_voltage_measure_routing_tb;
    logic i_core_clk = 1'b0;
    logic i_rst = 1'b1;
    hvmr_pkg::hvmr_bus_req_type bus;
    hvmr_pkg::hvmr_mode_type mode = hvmr_pkg::HVMR_MODE_NORMAL;
    logic sleep = 1'b0;
    logic other = 1'b0;
    logic hv = 1'b0;
    logic gio = 1'b0;
    logic [7:0] rdata;
    logic restart;
    logic irq;
    hvmr_pkg::hvmr_pin_ctrl_type pin;
    int errors = 0;
    int cmp_count = 0;
    int cyc = 0;
    // Rows: mode code above, expected switch state in bit 0
    logic [3:0] rows [7] = '{4'h0, 4'h3, 4'h4, 4'h6, 4'h8, 4'hA, 4'h3};
    initial forever #20 i_core_clk = ~i_core_clk;
    hvmr_host host_u (.i_core_clk(i_core_clk), .i_rdata(rdata), .o_bus(bus));
    hvmr_routing dut_u (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_bus(bus), .o_rdata(rdata), .i_mode(mode),
        .i_sleep_cmd(sleep), .i_other_wake_src(other), .o_restart_req(restart), .i_hv_sense_level(hv),
        .i_gio_level(gio), .o_pin(pin), .o_irq(irq));
    task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic summarize();
        if (errors == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Hang guard, well above the expected run
    always @(posedge i_core_clk) begin
        cyc++;
        if (cyc == 5000) begin
            errors++;
            summarize();
        end
    end
    initial begin
        logic [7:0] d;
        repeat (8) @(posedge i_core_clk);
        i_rst <= 1'b0;
        host_u.rd(`HVMR_ADDR_CTRL, d);
        chk("ctrl_reset", d, 8'h00);
        chk("switch_reset", pin.meas_switch, 8'h00);
        // Enable refused while the pin is a fail output
        host_u.wr(`HVMR_ADDR_IRQ_MASK, 8'h01);
        host_u.wr(`HVMR_ADDR_GIO_CFG, {5'h00, `HVMR_GIO_FAIL_OUT});
        host_u.wr(`HVMR_ADDR_CTRL, 8'h01);
        host_u.rd(`HVMR_ADDR_CTRL, d);
        chk("ctrl_refused", d[0], 8'h00);
        chk("irq_raised", irq, 8'h01);
        host_u.wr(`HVMR_ADDR_IRQ_STAT, 8'h01);
        @(posedge i_core_clk);
        #1;
        chk("irq_cleared", irq, 8'h00);
        host_u.wr(`HVMR_ADDR_GIO_CFG, 8'h00);
        host_u.wr(`HVMR_ADDR_CTRL, 8'h01);
        for (int i = 0; i < 7; i++) begin
            @(posedge i_core_clk) mode <= hvmr_pkg::hvmr_mode_type'(rows[i][3:1]);
            @(posedge i_core_clk);
            #1 chk("switch_mode", pin.meas_switch, rows[i][0]);
        end
        // Pin config change refused while measuring
        host_u.wr(`HVMR_ADDR_GIO_CFG, {5'h00, `HVMR_GIO_WAKE_IN});
        host_u.rd(`HVMR_ADDR_GIO_CFG, d);
        chk("gio_refused", d, 8'h00);
        host_u.rd(`HVMR_ADDR_IRQ_STAT, d);
        chk("gio_err", d[0], 8'h01);
        // Wake settings stored but without effect
        host_u.wr(`HVMR_ADDR_WAKE_CFG, 8'h0D);
        host_u.rd(`HVMR_ADDR_WAKE_CFG, d);
        chk("wake_cfg_stored", d, 8'h0D);
        chk("pull_off", pin.hv_pull_up, 8'h00);
        chk("wake_off", pin.hv_wake_active, 8'h00);
        chk("gio_wake_off", pin.gio_wake_active, 8'h00);
        @(posedge i_core_clk) hv <= 1'b1;
        repeat (8) @(posedge i_core_clk);
        host_u.rd(`HVMR_ADDR_WAKE_STAT, d);
        chk("wake_frozen", d, 8'h00);
        // Sleep with only pin wake sources
        host_u.wr(`HVMR_ADDR_IRQ_STAT, 8'h03);
        @(posedge i_core_clk) sleep <= 1'b1;
        @(posedge i_core_clk) sleep <= 1'b0;
        #1 chk("restart", restart, 8'h01);
        host_u.rd(`HVMR_ADDR_IRQ_STAT, d);
        chk("sleep_err", d[0], 8'h01);
        // Stored pull setting returns once disabled
        host_u.wr(`HVMR_ADDR_CTRL, 8'h00);
        #1 chk("pull_back", pin.hv_pull_up, 8'h01);
        chk("switch_off", pin.meas_switch, 8'h00);
        chk("pull_dn_back", pin.hv_pull_down, 8'h01);
        chk("hv_wake_back", pin.hv_wake_active, 8'h01);
        // Wake path live again once measuring is off
        @(posedge i_core_clk) hv <= 1'b0;
        repeat (6) @(posedge i_core_clk);
        host_u.rd(`HVMR_ADDR_WAKE_STAT, d);
        chk("wake_live", d, 8'h01);
        // Fail output and its test available when not measuring
        host_u.wr(`HVMR_ADDR_GIO_CFG, {5'h00, `HVMR_GIO_FAIL_OUT});
        host_u.wr(`HVMR_ADDR_CTRL, 8'h02);
        #1 chk("fail_drive", pin.gio_fail_drive, 8'h01);
        host_u.wr(`HVMR_ADDR_GIO_CFG, 8'h00);
        host_u.wr(`HVMR_ADDR_CTRL, 8'h01);
        #1 chk("switch_on", pin.meas_switch, 8'h01);
        chk("fail_drive_off", pin.gio_fail_drive, 8'h00);
        // Another wake source present: sleep is not refused
        @(posedge i_core_clk) begin
            sleep <= 1'b1;
            other <= 1'b1;
        end
        @(posedge i_core_clk) sleep <= 1'b0;
        #1 chk("no_restart", restart, 8'h00);
        // Reset in mid-run drops the enable and opens the switch
        @(posedge i_core_clk) i_rst <= 1'b1;
        repeat (2) @(posedge i_core_clk);
        #1 chk("switch_in_reset", pin.meas_switch, 8'h00);
        @(posedge i_core_clk) i_rst <= 1'b0;
        host_u.rd(`HVMR_ADDR_CTRL, d);
        chk("ctrl_after_reset", d, 8'h00);
        chk("switch_after_reset", pin.meas_switch, 8'h00);
        summarize();
    end
endmodule
`default_nettype wire

//--- sim/hvmr_host.sv
// Purpose: Host model driving the register port
// Assumes: Read data stand in the cycle after the read strobe
// Notes: Strobes last one cycle and change just after a rising edge
`timescale 1ns/10ps
`default_nettype none
module hvmr_host (
    // Clock and read data
    input wire logic i_core_clk,
    input wire logic [7:0] i_rdata,
    // Register port request
    output hvmr_pkg::hvmr_bus_req_type o_bus
);
    initial o_bus = '0;
    // One-cycle write strobe
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_core_clk) o_bus <= '{a, d, 1'b1, 1'b0};
        @(posedge i_core_clk) o_bus.wr <= 1'b0;
    endtask
    // Read strobe, data taken in the following cycle
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge i_core_clk) o_bus <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge i_core_clk) o_bus.rd <= 1'b0;
        #1 d = i_rdata;
    endtask
endmodule
`default_nettype wire

//--- sim/hvmr_monitor.sv
// Purpose: Port checker for the measurement routing block
// Assumes: One clock, reset active high
// Notes: Bound to the design at the foot of this file
`include "hvmr_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module hvmr_monitor (
    // Clock and inputs
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire hvmr_pkg::hvmr_bus_req_type i_bus,
    input wire hvmr_pkg::hvmr_mode_type i_mode,
    input wire logic i_sleep_cmd,
    input wire logic i_other_wake_src,
    // Outputs watched
    input wire logic o_restart_req,
    input wire hvmr_pkg::hvmr_pin_ctrl_type o_pin
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    // A control write that clears the enable bit
    sequence s_dis_wr;
        i_bus.wr && i_bus.addr == `HVMR_ADDR_CTRL && !i_bus.wdata[0];
    endsequence
    AST_SW_NORMAL: assert property (o_pin.meas_switch |-> i_mode == hvmr_pkg::HVMR_MODE_NORMAL)
        else $error("switch closed outside normal mode");
    AST_SW_RESET: assert property (disable iff (1'b0) i_rst |-> !o_pin.meas_switch)
        else $error("switch closed in reset");
    AST_SW_FAILSAFE: assert property (i_mode == hvmr_pkg::HVMR_MODE_FAILSAFE |-> !o_pin.meas_switch)
        else $error("switch closed in fail-safe");
    AST_PULLS_OFF: assert property (o_pin.meas_switch |-> !o_pin.hv_pull_up && !o_pin.hv_pull_down)
        else $error("pull active while measuring");
    AST_FUNC_OFF: assert property (o_pin.meas_switch |-> !(o_pin.gio_fail_drive || o_pin.gio_wake_active || o_pin.hv_wake_active))
        else $error("pin function active while measuring");
    AST_DISABLE: assert property (s_dis_wr |=> !o_pin.meas_switch)
        else $error("switch stays closed after disable");
    AST_SW_HOLD: assert property (o_pin.meas_switch && !(i_bus.wr && i_bus.addr == `HVMR_ADDR_CTRL)
        |=> o_pin.meas_switch || i_mode != hvmr_pkg::HVMR_MODE_NORMAL) else $error("switch opened without cause");
    AST_RESTART_CAUSE: assert property (o_restart_req |-> $past(i_sleep_cmd) && !$past(i_other_wake_src))
        else $error("restart without sleep request");
    AST_RESTART_PULSE: assert property (o_restart_req |=> !o_restart_req)
        else $error("restart request longer than one cycle");
endmodule
bind hvmr_routing hvmr_monitor mon_u (.i_core_clk, .i_rst, .i_bus, .i_mode, .i_sleep_cmd, .i_other_wake_src,
    .o_restart_req, .o_pin);
`default_nettype wire
